/* File: hdl/ams_acq_seq.sv */
// Acquisition memory sequencer: ring, streaming and multiple recording
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ams_params.svh"
module ams_acq_seq import ams_pkg::*; #(
    parameter int MEM_AW = 30,
    parameter int NUM_MFO = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`AMS_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [31:0] sample_data,
    input wire logic trig_int,
    input wire logic trig_pin,
    output logic mem_we,
    output logic [MEM_AW-1:0] mem_waddr,
    output logic [31:0] mem_wdata,
    output logic mem_re,
    output logic [MEM_AW-1:0] mem_raddr,
    input wire logic [31:0] mem_rdata,
    output logic stream_valid,
    output logic [31:0] stream_data,
    input wire logic stream_ready,
    output logic [NUM_MFO-1:0] mfo_out,
    output logic irq
);
    if (MEM_AW < 4 || MEM_AW > 30) begin : g_chk_aw
        $error("MEM_AW must lie between 4 and 30");
    end
    if (NUM_MFO < 1 || NUM_MFO > 10) begin : g_chk_mfo
        $error("NUM_MFO must lie between 1 and 10");
    end

    localparam int PW = MEM_AW + 1;
    localparam int SW = NUM_MFO * `AMS_MFO_SEL_W;
    localparam logic [PW-1:0] DEPTH = {1'b1, {MEM_AW{1'b0}}};
    localparam logic [PW-1:0] ONE = {{MEM_AW{1'b0}}, 1'b1};

    typedef struct packed {
        ams_state_t st;
        ams_mode_t mode;
        logic [PW-1:0] seg_size;
        logic [PW-1:0] post;
        logic [PW-1:0] notify;
        logic [PW-1:0] base;
        logic [PW-1:0] rd;
        logic [PW-1:0] off;
        logic [PW-1:0] prefill;
        logic [PW-1:0] postcnt;
        logic [PW-1:0] nsent;
        logic [31:0] seg_cnt;
        logic [MEM_AW-1:0] trig_pos;
        logic [`AMS_IRQ_W-1:0] irq_stat;
        logic [`AMS_IRQ_W-1:0] irq_mask;
        logic [SW-1:0] mfo_sel;
        logic [NUM_MFO-1:0] gpo;
        logic [NUM_MFO-1:0] mfo;
        logic trig_lvl_d;
        logic trig_out;
        logic we;
        logic [MEM_AW-1:0] waddr;
        logic [31:0] wdata;
        logic re;
        logic pend;
        logic [MEM_AW-1:0] raddr;
        logic sval;
        logic [31:0] sdata;
        logic [31:0] prdata;
        logic irq;
    } ams_st_t;

    ams_st_t q;
    ams_st_t d;
    logic trig_lvl;

    // Pointer distance; pointers carry one extra bit for full versus empty
    function automatic logic [PW-1:0] ptr_sub(input logic [PW-1:0] a,
                                              input logic [PW-1:0] b);
        return a - b;
    endfunction

    function automatic logic addr_mapped(input logic [`AMS_PADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && (a <= `AMS_GPO_ADDR);
    endfunction

    ams_sync3 u_trig_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(trig_pin),
        .level(trig_lvl)
    );

    logic wr_acc;
    logic rd_setup;
    logic arm_req;
    logic stop_req;
    logic force_req;
    logic trig_req;
    logic seg_end;
    logic [PW-1:0] pre;
    logic [PW-1:0] nbase;
    logic [PW:0] next_end;
    logic [`AMS_IRQ_W-1:0] ev;
    logic take;
    logic [`AMS_MFO_SEL_W-1:0] sel;

    always_comb begin
        d = q;
        ev = '0;
        seg_end = 1'b0;
        sel = '0;
        d.we = 1'b0;
        d.re = 1'b0;
        d.trig_out = 1'b0;
        wr_acc = psel && penable && pwrite && addr_mapped(paddr);
        rd_setup = psel && !penable && !pwrite;
        arm_req = wr_acc && paddr == `AMS_CTRL_ADDR && pwdata[`AMS_CTRL_ARM];
        stop_req = wr_acc && paddr == `AMS_CTRL_ADDR
                   && pwdata[`AMS_CTRL_STOP];
        force_req = wr_acc && paddr == `AMS_CTRL_ADDR
                    && pwdata[`AMS_CTRL_FORCE];
        trig_req = (trig_lvl && !q.trig_lvl_d) || trig_int || force_req;
        d.trig_lvl_d = trig_lvl;
        pre = q.seg_size - q.post;
        nbase = q.base + q.seg_size;
        next_end = {1'b0, nbase} + {1'b0, q.seg_size};

        if (wr_acc) begin
            unique case (paddr)
                `AMS_CTRL_ADDR: begin
                    d.mode = ams_mode_t'(pwdata[`AMS_CTRL_MODE +: 2]);
                end
                `AMS_SEGSIZE_ADDR: d.seg_size = pwdata[PW-1:0];
                `AMS_POST_ADDR: d.post = pwdata[PW-1:0];
                `AMS_NOTIFY_ADDR: d.notify = pwdata[PW-1:0];
                `AMS_IRQ_MASK_ADDR: d.irq_mask = pwdata[`AMS_IRQ_W-1:0];
                `AMS_MFO_SEL_ADDR: d.mfo_sel = pwdata[SW-1:0];
                `AMS_GPO_ADDR: d.gpo = pwdata[NUM_MFO-1:0];
                default: ;
            endcase
        end

        unique case (q.st)
            AMS_PREFILL, AMS_ARMED: begin
                if (sample_valid) begin
                    d.we = 1'b1;
                    d.waddr = q.base[MEM_AW-1:0] + q.off[MEM_AW-1:0];
                    d.wdata = sample_data;
                    d.off = (q.off + ONE >= q.seg_size) ? '0 : q.off + ONE;
                    if (q.prefill < pre) begin
                        d.prefill = q.prefill + ONE;
                    end
                end
                if (q.st == AMS_PREFILL && d.prefill >= pre) begin
                    d.st = AMS_ARMED;
                end
                // Trigger taken once the pre area holds data
                if (q.st == AMS_ARMED && trig_req) begin
                    ev[`AMS_IRQ_TRIG] = 1'b1;
                    d.trig_out = 1'b1;
                    d.trig_pos = q.base[MEM_AW-1:0] + d.off[MEM_AW-1:0];
                    d.postcnt = q.post;
                    if (q.post == '0) begin
                        seg_end = 1'b1;
                    end else begin
                        d.st = AMS_POST;
                    end
                end
            end
            AMS_POST: begin
                if (sample_valid) begin
                    d.we = 1'b1;
                    d.waddr = q.base[MEM_AW-1:0] + q.off[MEM_AW-1:0];
                    d.wdata = sample_data;
                    d.off = (q.off + ONE >= q.seg_size) ? '0 : q.off + ONE;
                    d.postcnt = q.postcnt - ONE;
                    seg_end = (q.postcnt == ONE);
                end
            end
            AMS_STREAM: begin
                // Whole memory used as elastic buffer
                if (sample_valid) begin
                    if (ptr_sub(q.base, q.rd) == DEPTH) begin
                        ev[`AMS_IRQ_OVERRUN] = 1'b1;
                        d.st = AMS_DONE;
                    end else begin
                        d.we = 1'b1;
                        d.waddr = q.base[MEM_AW-1:0];
                        d.wdata = sample_data;
                        d.base = q.base + ONE;
                    end
                end
            end
            AMS_IDLE, AMS_DONE: ;
            default: d.st = AMS_IDLE;
        endcase

        if (seg_end) begin
            d.seg_cnt = q.seg_cnt + 32'h0000_0001;
            d.off = '0;
            d.prefill = '0;
            unique case (q.mode)
                AMS_MODE_MULTI: begin
                    // Stop when the next segment would not fit
                    // Bound is memory over segment size
                    if (next_end > {1'b0, DEPTH}) begin
                        d.st = AMS_DONE;
                        ev[`AMS_IRQ_READY] = 1'b1;
                    end else begin
                        d.base = nbase;
                        d.st = AMS_PREFILL;
                    end
                end
                AMS_MODE_MULTI_FIFO: begin
                    // Unbounded while the host keeps up
                    d.base = nbase;
                    d.st = AMS_PREFILL;
                    if (ptr_sub(DEPTH, ptr_sub(nbase, q.rd)) < q.seg_size)
                    begin
                        d.st = AMS_DONE;
                        ev[`AMS_IRQ_OVERRUN] = 1'b1;
                    end
                end
                default: begin
                    d.st = AMS_DONE;
                    ev[`AMS_IRQ_READY] = 1'b1;
                end
            endcase
        end

        // Read side toward the transfer engine, streaming modes only
        take = q.sval && stream_ready;
        if (take) begin
            d.sval = 1'b0;
            if (q.notify != '0 && q.nsent + ONE >= q.notify) begin
                d.nsent = '0;
                ev[`AMS_IRQ_NOTIFY] = 1'b1;
            end else begin
                d.nsent = q.nsent + ONE;
            end
        end
        d.pend = q.re;
        if (q.pend) begin
            d.sval = 1'b1;
            d.sdata = mem_rdata;
        end
        // Drain words below base: each sample at once in streaming, whole segments in multiple FIFO
        if (q.mode[0] && q.base != q.rd && !q.re && !q.pend
            && (!q.sval || stream_ready)) begin
            d.re = 1'b1;
            d.raddr = q.rd[MEM_AW-1:0];
            d.rd = q.rd + ONE;
        end

        if (stop_req) begin
            d.st = AMS_IDLE;
        end
        // A bad geometry makes arming a no-op rather than a wild write
        if (arm_req && q.seg_size != '0 && q.seg_size <= DEPTH
            && q.post <= q.seg_size) begin
            d.st = (d.mode == AMS_MODE_FIFO) ? AMS_STREAM : AMS_PREFILL;
            d.base = '0;
            d.rd = '0;
            d.off = '0;
            d.prefill = '0;
            d.nsent = '0;
            d.seg_cnt = '0;
            d.sval = 1'b0;
            d.re = 1'b0;
            d.pend = 1'b0;
        end

        // Set wins over a write-one-to-clear in the same cycle
        d.irq_stat = q.irq_stat;
        if (wr_acc && paddr == `AMS_IRQ_STAT_ADDR) begin
            d.irq_stat = q.irq_stat & ~pwdata[`AMS_IRQ_W-1:0];
        end
        d.irq_stat = d.irq_stat | ev;
        d.irq = |(q.irq_stat & q.irq_mask);

        for (int i = 0; i < NUM_MFO; i++) begin
            sel = q.mfo_sel[i*`AMS_MFO_SEL_W +: `AMS_MFO_SEL_W];
            case (ams_mfo_sel_t'(sel))
                AMS_MFO_TRIG: d.mfo[i] = q.trig_out;
                AMS_MFO_ARMED: d.mfo[i] = (q.st == AMS_PREFILL)
                    || (q.st == AMS_ARMED) || (q.st == AMS_STREAM);
                AMS_MFO_TRIGGERED: d.mfo[i] = (q.st == AMS_POST);
                AMS_MFO_READY: d.mfo[i] = (q.st == AMS_DONE);
                AMS_MFO_GPO: d.mfo[i] = q.gpo[i];
                default: d.mfo[i] = 1'b0;
            endcase
        end

        // Read data is latched in the setup phase so it comes from a flop
        if (rd_setup) begin
            d.prdata = `AMS_RST_ZERO;
            unique case (paddr)
                `AMS_CTRL_ADDR: d.prdata[`AMS_CTRL_MODE +: 2] = q.mode;
                `AMS_STATUS_ADDR: begin
                    d.prdata[`AMS_ST_ARMED] = (q.st == AMS_PREFILL)
                        || (q.st == AMS_ARMED) || (q.st == AMS_STREAM);
                    d.prdata[`AMS_ST_TRIGGERED] = (q.st == AMS_POST);
                    d.prdata[`AMS_ST_READY] = (q.st == AMS_DONE);
                    d.prdata[`AMS_ST_CODE +: 3] = q.st;
                end
                `AMS_SEGSIZE_ADDR: d.prdata[PW-1:0] = q.seg_size;
                `AMS_POST_ADDR: d.prdata[PW-1:0] = q.post;
                `AMS_SEGCNT_ADDR: d.prdata = q.seg_cnt;
                `AMS_TRIGPOS_ADDR: d.prdata[MEM_AW-1:0] = q.trig_pos;
                `AMS_NOTIFY_ADDR: d.prdata[PW-1:0] = q.notify;
                `AMS_FILL_ADDR: d.prdata[PW-1:0] = ptr_sub(q.base, q.rd);
                `AMS_IRQ_STAT_ADDR: d.prdata[`AMS_IRQ_W-1:0] = q.irq_stat;
                `AMS_IRQ_MASK_ADDR: d.prdata[`AMS_IRQ_W-1:0] = q.irq_mask;
                `AMS_MFO_SEL_ADDR: d.prdata[SW-1:0] = q.mfo_sel;
                `AMS_GPO_ADDR: d.prdata[NUM_MFO-1:0] = q.gpo;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Zero wait states; unmapped or misaligned addresses answer an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata = q.prdata;
    assign mem_we = q.we;
    assign mem_waddr = q.waddr;
    assign mem_wdata = q.wdata;
    assign mem_re = q.re;
    assign mem_raddr = q.raddr;
    assign stream_valid = q.sval;
    assign stream_data = q.sdata;
    assign mfo_out = q.mfo;
    assign irq = q.irq;
endmodule // ams_acq_seq
`default_nettype wire

/* File: hdl/ams_sync3.sv */
// Three-stage synchroniser for a pin, with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ams_sync3 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ams_sync_st_t;

    ams_sync_st_t q;
    ams_sync_st_t d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Only a level seen on two late stages alike is passed on
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.lvl;
endmodule // ams_sync3
`default_nettype wire

/* File: inc/ams_params.svh */
// Register map, field positions and reset values of the acquisition sequencer
//
// Operation
// - In ring mode, while armed and untriggered, every sample is written into a circular memory area, overwriting the oldest.
// - After a trigger, the programmed post-trigger count is recorded and the earlier samples stay as pre-trigger data.
// - The pre-trigger sample count equals the ring size minus the post-trigger count.
// - In streaming mode, samples flow continuously toward the host, using the whole memory as an elastic buffer.
// - In streaming mode the device raises interrupts that pace the host, and the host services them to keep data moving.
// - In multiple-recording mode the block re-arms after each segment with no restart, leaving a minimal gap.
// - In multiple-recording mode the memory is split into segments that all share one programmed size.
// - In multiple-recording mode each trigger fills the next segment with samples.
// - In multiple-recording mode the pre- and post-trigger counts of a segment are programmable.
// - The segment count is bounded by memory over segment size, and unbounded when combined with streaming.
// - Each multi-function output selects trigger output, armed, triggered, ready or a general-purpose level.
`ifndef AMS_PARAMS_SVH
`define AMS_PARAMS_SVH

`define AMS_PADDR_W 8
`define AMS_CTRL_ADDR 8'h00
`define AMS_STATUS_ADDR 8'h04
`define AMS_SEGSIZE_ADDR 8'h08
`define AMS_POST_ADDR 8'h0C
`define AMS_SEGCNT_ADDR 8'h10
`define AMS_TRIGPOS_ADDR 8'h14
`define AMS_NOTIFY_ADDR 8'h18
`define AMS_FILL_ADDR 8'h1C
`define AMS_IRQ_STAT_ADDR 8'h20
`define AMS_IRQ_MASK_ADDR 8'h24
`define AMS_MFO_SEL_ADDR 8'h28
`define AMS_GPO_ADDR 8'h2C

`define AMS_CTRL_ARM 0
`define AMS_CTRL_STOP 1
`define AMS_CTRL_FORCE 2
`define AMS_CTRL_MODE 4

`define AMS_ST_ARMED 0
`define AMS_ST_TRIGGERED 1
`define AMS_ST_READY 2
`define AMS_ST_CODE 4

`define AMS_IRQ_W 4
`define AMS_IRQ_TRIG 0
`define AMS_IRQ_READY 1
`define AMS_IRQ_NOTIFY 2
`define AMS_IRQ_OVERRUN 3

`define AMS_MFO_SEL_W 3
`define AMS_RST_ZERO 32'h0000_0000

`endif

/* File: inc/ams_pkg.sv */
// Types shared by the acquisition sequencer modules
package ams_pkg;

    typedef enum logic [2:0] {
        AMS_IDLE = 3'b000,
        AMS_PREFILL = 3'b001,
        AMS_ARMED = 3'b010,
        AMS_POST = 3'b011,
        AMS_STREAM = 3'b100,
        AMS_DONE = 3'b101
    } ams_state_t;

    typedef enum logic [1:0] {
        AMS_MODE_RING = 2'b00,
        AMS_MODE_FIFO = 2'b01,
        AMS_MODE_MULTI = 2'b10,
        AMS_MODE_MULTI_FIFO = 2'b11
    } ams_mode_t;

    typedef enum logic [2:0] {
        AMS_MFO_TRIG = 3'h0,
        AMS_MFO_ARMED = 3'h1,
        AMS_MFO_TRIGGERED = 3'h2,
        AMS_MFO_READY = 3'h3,
        AMS_MFO_GPO = 3'h4
    } ams_mfo_sel_t;

endpackage

/* File: sim/acquisition_memory_sequencer_tb.sv */
// Self-checking bench for the acquisition sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ams_params.svh"
`define CHK(g, e) chk(64'(g), 64'(e))
module acquisition_memory_sequencer_tb import ams_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic sample_valid = 0, trig_int = 0, trig_pin = 0, slow = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, sample_data = 32'h0, rnd = 32'h1285;
    logic [31:0] prdata, mem_wdata, mem_rdata, stream_data;
    logic [3:0] mem_waddr, mem_raddr;
    logic pready, pslverr, mem_we, mem_re, stream_valid, stream_ready, irq;
    logic [2:0] mfo_out;
    logic [32:0] exp_rd[$];
    logic [35:0] exp_wr[$];
    logic [31:0] exp_st[$];
    int failures = 0, n_tests = 0;
    bit fifo = 0;
    logic [31:0] seg_w [4];

    ams_acq_seq #(.MEM_AW(4), .NUM_MFO(3)) u_dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_data(sample_data), .trig_int(trig_int), .trig_pin(trig_pin),
        .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
        .mem_re(mem_re), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
        .stream_valid(stream_valid), .stream_data(stream_data),
        .stream_ready(stream_ready), .mfo_out(mfo_out), .irq(irq));
    ams_host_model #(.AW(4)) u_host (.pclk(pclk), .presetn(presetn),
        .slow(slow), .mem_we(mem_we), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .mem_re(mem_re), .mem_raddr(mem_raddr),
        .mem_rdata(mem_rdata), .stream_ready(stream_ready));

    initial forever #2.5 pclk = ~pclk;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic complete_run;
        $display("Mismatches %0d, comparisons %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // One sample per call; e says whether a memory write must follow
    task automatic smp(input int a, input logic t, input logic e);
        rnd = lfsr(rnd);
        sample_valid <= 1'b1;
        sample_data <= rnd;
        trig_int <= t;
        if (e)
            exp_wr.push_back({4'(a), rnd});
        if (e && fifo)
            exp_st.push_back(rnd);
        @(posedge pclk);
    endtask

    task automatic idle(input int n);
        sample_valid <= 1'b0;
        trig_int <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        if (presetn && psel && penable && pready && !pwrite)
            `CHK({pslverr, prdata}, exp_rd.size() ? exp_rd.pop_front() : 'x);
        if (mem_we)
            `CHK({mem_waddr, mem_wdata}, exp_wr.size() ? exp_wr.pop_front() : 'x);
        if (stream_valid && stream_ready)
            `CHK(stream_data, exp_st.size() ? exp_st.pop_front() : 'x);
    end

    // Whole run is well under 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`AMS_STATUS_ADDR, 33'h0);
        rd(`AMS_IRQ_STAT_ADDR, 33'h0);
        rd(8'h30, {1'b1, 32'h0});
        apb(1'b1, `AMS_SEGSIZE_ADDR, 32'h4);
        apb(1'b1, `AMS_POST_ADDR, 32'h2);
        apb(1'b1, `AMS_MFO_SEL_ADDR, 32'h88);
        apb(1'b1, `AMS_CTRL_ADDR, 32'h01);
        for (int i = 0; i < 5; i++)
            smp(i % 4, 1'b0, 1'b1);
        idle(2);
        `CHK(mfo_out, 3'b010);
        smp(1, 1'b1, 1'b1);
        idle(2);
        `CHK(mfo_out, 3'b101);
        idle(1);
        `CHK(mfo_out, 3'b100);
        smp(2, 1'b0, 1'b1);
        smp(3, 1'b0, 1'b1);
        smp(0, 1'b0, 1'b0);
        idle(3);
        rd(`AMS_STATUS_ADDR, 33'h54);
        rd(`AMS_TRIGPOS_ADDR, 33'h2);
        rd(`AMS_IRQ_STAT_ADDR, 33'h3);
        `CHK(irq, 1'b0);
        apb(1'b1, `AMS_IRQ_MASK_ADDR, 32'h3);
        idle(2);
        `CHK(irq, 1'b1);
        apb(1'b1, `AMS_IRQ_STAT_ADDR, 32'h3);
        idle(2);
        `CHK(irq, 1'b0);
        apb(1'b1, `AMS_POST_ADDR, 32'h1);
        apb(1'b1, `AMS_CTRL_ADDR, 32'h21);
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 3; i++)
                smp(4 * s + i, 1'b0, 1'b1);
            idle(1);
            if (s == 1) begin
                trig_pin <= 1'b1;
                idle(8);
                trig_pin <= 1'b0;
            end else if (s == 2) begin
                apb(1'b1, `AMS_CTRL_ADDR, 32'h24);
            end else begin
                smp(4 * s + 3, 1'b1, 1'b1);
            end
            smp(4 * s + ((s == 1 || s == 2) ? 3 : 0), 1'b0, 1'b1);
            idle(2);
        end
        rd(`AMS_STATUS_ADDR, 33'h54);
        rd(`AMS_SEGCNT_ADDR, 33'h4);
        rd(`AMS_TRIGPOS_ADDR, 33'hC);
        smp(0, 1'b0, 1'b0);
        idle(2);
        apb(1'b1, `AMS_MFO_SEL_ADDR, 32'h23);
        apb(1'b1, `AMS_GPO_ADDR, 32'h2);
        idle(2);
        `CHK(mfo_out, 3'b011);
        apb(1'b1, `AMS_IRQ_STAT_ADDR, 32'hF);
        apb(1'b1, `AMS_NOTIFY_ADDR, 32'h2);
        apb(1'b1, `AMS_IRQ_MASK_ADDR, 32'h4);
        slow <= 1'b1;
        fifo = 1;
        apb(1'b1, `AMS_CTRL_ADDR, 32'h11);
        for (int i = 0; i < 6; i++)
            smp(i, 1'b0, 1'b1);
        idle(1);
        for (int i = 0; i < 400 && exp_st.size() != 0; i++)
            @(posedge pclk);
        idle(4);
        `CHK(irq, 1'b1);
        rd(`AMS_IRQ_STAT_ADDR, 33'h4);
        rd(`AMS_CTRL_ADDR, 33'h10);
        apb(1'b1, `AMS_CTRL_ADDR, 32'h02);
        fifo = 0;
        apb(1'b1, `AMS_CTRL_ADDR, 32'h31);
        for (int i = 0; i < 5; i++) begin
            smp(i % 4, i == 3, 1'b1);
            seg_w[i % 4] = rnd;
        end
        idle(1);
        for (int i = 0; i < 4; i++)
            exp_st.push_back(seg_w[i]);
        for (int i = 0; i < 400 && exp_st.size() != 0; i++)
            @(posedge pclk);
        rd(`AMS_SEGCNT_ADDR, 33'h1);
        idle(2);
        `CHK(exp_wr.size() + exp_st.size(), 0);
        complete_run();
    end
endmodule // acquisition_memory_sequencer_tb
`default_nettype wire

/* File: sim/ams_acq_seq_checker.sv */
// Port-level checks for the acquisition sequencer
`timescale 1ns/100ps
`default_nettype none
module ams_acq_seq_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire logic [31:0] sample_data,
    input wire logic mem_we,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_re,
    input wire logic [31:0] mem_rdata,
    input wire logic stream_valid,
    input wire logic [31:0] stream_data,
    input wire logic stream_ready
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    slverr_map_a:
    assert property (psel && penable |->
        pslverr == (paddr > 8'h2C || paddr[1:0] != 2'h0))
        else $error("error response does not match address");
    zero_wait_a:
    assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    write_cause_a:
    assert property (mem_we |-> $past(sample_valid))
        else $error("memory write without a sample");
    write_data_a:
    assert property (mem_we |-> mem_wdata == $past(sample_data))
        else $error("memory write data is not the sample");
    read_gap_a:
    assert property (mem_re |=> !mem_re [*2])
        else $error("memory reads closer than three cycles");
    read_data_a:
    assert property (mem_re |-> ##2 (stream_valid &&
        stream_data == $past(mem_rdata)))
        else $error("stream word does not follow memory read");
    valid_src_a:
    assert property ($rose(stream_valid) |-> $past(mem_re, 2))
        else $error("stream word without a memory read");
    stream_hold_a:
    assert property (stream_valid && !stream_ready |=>
        stream_valid && $stable(stream_data))
        else $error("stream word dropped or changed while stalled");

    cover property (mem_we && sample_valid);
    cover property (stream_valid && stream_ready);
    cover property (psel && penable && pslverr);
endmodule // ams_acq_seq_checker

bind ams_acq_seq ams_acq_seq_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_re(mem_re),
    .mem_rdata(mem_rdata), .stream_valid(stream_valid),
    .stream_data(stream_data), .stream_ready(stream_ready));
`default_nettype wire

/* File: sim/ams_host_model.sv */
// Far-side model: acquisition memory and host transfer sink
`timescale 1ns/100ps
`default_nettype none
module ams_host_model #(
    parameter int AW = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_we,
    input wire logic [AW-1:0] mem_waddr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_re,
    input wire logic [AW-1:0] mem_raddr,
    output logic [31:0] mem_rdata,
    output logic stream_ready
);
    logic [31:0] ram [2**AW];
    logic [1:0] cnt_q;

    always @(posedge pclk) begin
        if (mem_we)
            ram[mem_waddr] <= mem_wdata;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rdata <= 32'h5A5A_5A5A;
            cnt_q <= 2'h0;
            stream_ready <= 1'b0;
        end else begin
            // Read data only holds for one cycle; it toggles otherwise
            mem_rdata <= mem_re ? ram[mem_raddr] : ~mem_rdata;
            cnt_q <= cnt_q + 2'h1;
            stream_ready <= !slow || cnt_q == 2'h3;
        end
    end
endmodule // ams_host_model
`default_nettype wire
